// ==== core/adc_select.sv ====
// Input selection, selection buffering and result formatting around a 10-bit converter
// Assumes the converter core pulses conversion start and last-cycle, and hands over a raw sample
// Functional notes
// - after completion the 10-bit result is readable across low and high result registers
// - single-ended result is unsigned, 0x000 ground to 0x3FF reference minus one step
// - differential result is two's complement 0x200 to 0x1FF, clamped at 0x1FF
// - eight-bit select register resets to zero; ref 7:6, align 5, channel 4:0
// - reference 00 external pin, 01 analog supply, 10 reserved, 11 internal 1.1V
// - reference and channel changes during conversion apply only after completion
// - align bit one left-adjusts, zero right-adjusts, effective immediately
// - codes 0-7 single inputs, 11110 bandgap, 11111 ground, 01000-01111 nothing
// - 10000-10111 pairs against input 1; 11000-11101 pairs against input 2
// - selection copies until start, locks during conversion, resumes in last cycle
`timescale 1ns/1ps
`default_nettype none
`include "adc_select_defs.svh"

module adc_select
(
  input wire logic aclk, // 200 MHz clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [11:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [11:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic conversion_start, // Pulse: converter starts sampling
  input wire logic conversion_last, // Pulse: last converter cycle before completion
  input wire logic [10:0] raw_sample, // Raw sample, bit 10 set means above full scale
  output adc_select_pkg::analog_route_type analog_route, // Locked routing to the analog front end
  output logic conversion_done_flag, // Result valid, cleared by write of bit 0 of clear
  output logic irq // Level interrupt
);
  import adc_select_pkg::*;

  state_type cur;
  state_type next_cur;

  // ==========================================================
  // Helpers
  function automatic analog_route_type decode_route(input sel_type s);
    analog_route_type r;
    r = '0;
    r.reference_select = s.reference_select;
    r.valid = (s.reference_select != `REF_RESERVED);
    if (s.channel_code <= `CHAN_SE_LAST)
    begin
      r.valid = r.valid;
      r.positive_input = {1'b0, s.channel_code[2:0]};
    end
    else if (s.channel_code < `CHAN_DIFF1_FIRST)
    begin
      r.valid = 1'b0;
    end
    else if (s.channel_code < `CHAN_DIFF2_FIRST)
    begin
      r.differential = 1'b1;
      r.positive_input = {1'b0, s.channel_code[2:0]};
      r.negative_input = 4'h1;
    end
    else if (s.channel_code <= `CHAN_DIFF2_LAST)
    begin
      r.differential = 1'b1;
      r.positive_input = {1'b0, s.channel_code[2:0]};
      r.negative_input = 4'h2;
    end
    else if (s.channel_code == `CHAN_BANDGAP)
    begin
      r.positive_input = 4'h8;
    end
    else
    begin
      r.positive_input = 4'h9;
    end
    return r;
  endfunction

  function automatic logic [9:0] format_code(input logic [10:0] raw, input logic diff);
    logic [9:0] v;
    v = raw[9:0];
    if (!diff && raw[10])
    begin
      v = `SE_MAX;
    end
    if (diff && raw[10] && !raw[9])
    begin
      v = `DIFF_MAX;
    end
    return v;
  endfunction

  function automatic logic [15:0] present(input logic [9:0] res, input logic left);
    logic [15:0] p;
    p = left ? {res, 6'h00} : {6'h00, res};
    return p;
  endfunction

  logic [15:0] result_word;
  logic wr_fire;
  logic rd_fire;
  logic [31:0] rd_value;
  logic [1:0] rd_resp;
  analog_route_type active_route;

  assign result_word = present(cur.result, cur.sel.result_left_align);
  assign active_route = decode_route(cur.active);
  assign wr_fire = cur.aw_held && cur.w_held && !cur.bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  // ==========================================================
  // Read decode
  always_comb
  begin
    rd_value = 32'h0000_0000;
    rd_resp = `OKAY;
    case (s_axi_araddr)
      `SEL_ADDR: rd_value = {24'h00_0000, cur.sel};
      `RESULT_LOW_ADDR: rd_value = {24'h00_0000, result_word[7:0]};
      `RESULT_HIGH_ADDR: rd_value = {24'h00_0000, result_word[15:8]};
      `IRQ_STATUS_ADDR: rd_value = {30'h0000_0000, cur.irq_status};
      `IRQ_CLEAR_ADDR: rd_value = 32'h0000_0000;
      `IRQ_ENABLE_ADDR: rd_value = {30'h0000_0000, cur.irq_enable};
      `CONV_STATUS_ADDR: rd_value = {30'h0000_0000, cur.state == BUSY, cur.done_flag};
      default: rd_resp = `SLVERR;
    endcase
  end

  // ==========================================================
  // Next state
  always_comb
  begin
    next_cur = cur;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_cur.aw_held = 1'b1;
      next_cur.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_cur.w_held = 1'b1;
      next_cur.wdata = s_axi_wdata;
      next_cur.wstrb = s_axi_wstrb;
    end
    if (cur.bvalid && s_axi_bready)
    begin
      next_cur.bvalid = 1'b0;
    end
    if (cur.rvalid && s_axi_rready)
    begin
      next_cur.rvalid = 1'b0;
    end

    // Interrupt clear first so that a same-cycle event wins
    if (wr_fire)
    begin
      next_cur.aw_held = 1'b0;
      next_cur.w_held = 1'b0;
      next_cur.bvalid = 1'b1;
      next_cur.bresp = `OKAY;
      case (cur.awaddr)
        `SEL_ADDR:
        begin
          if (cur.wstrb[0])
          begin
            next_cur.sel = cur.wdata[7:0];
          end
        end
        `IRQ_CLEAR_ADDR:
        begin
          if (cur.wstrb[0])
          begin
            next_cur.irq_status = cur.irq_status & ~cur.wdata[1:0];
            if (cur.wdata[0])
            begin
              next_cur.done_flag = 1'b0;
            end
          end
        end
        `IRQ_ENABLE_ADDR:
        begin
          if (cur.wstrb[0])
          begin
            next_cur.irq_enable = cur.wdata[1:0];
          end
        end
        `RESULT_LOW_ADDR, `RESULT_HIGH_ADDR, `IRQ_STATUS_ADDR, `CONV_STATUS_ADDR: next_cur.bresp = `OKAY;
        default: next_cur.bresp = `SLVERR;
      endcase
    end

    if (rd_fire)
    begin
      next_cur.rvalid = 1'b1;
      next_cur.rdata = rd_value;
      next_cur.rresp = rd_resp;
    end

    // Selection buffer: copy while idle and in the last cycle, lock while busy
    case (cur.state)
      IDLE:
      begin
        next_cur.active = next_cur.sel;
        if (conversion_start)
        begin
          next_cur.active = cur.sel;
          next_cur.state = BUSY;
        end
      end
      BUSY:
      begin
        if (conversion_last)
        begin
          next_cur.active = cur.sel;
          next_cur.state = IDLE;
          next_cur.result = format_code(raw_sample, active_route.differential);
          next_cur.done_flag = 1'b1;
          next_cur.irq_status[0] = 1'b1;
          if (cur.sel != cur.active)
          begin
            next_cur.irq_status[1] = 1'b1;
          end
        end
      end
      default: next_cur.state = IDLE;
    endcase

    if (!aresetn)
    begin
      next_cur = '0;
      next_cur.sel = `SEL_RESET;
      next_cur.active = `SEL_RESET;
      next_cur.state = IDLE;
    end
  end

  always_ff @(posedge aclk)
  begin
    cur <= next_cur;
  end

  // ==========================================================
  // Outputs
  assign s_axi_awready = !cur.aw_held && !cur.bvalid;
  assign s_axi_wready = !cur.w_held && !cur.bvalid;
  assign s_axi_bvalid = cur.bvalid;
  assign s_axi_bresp = cur.bresp;
  assign s_axi_arready = !cur.rvalid;
  assign s_axi_rvalid = cur.rvalid;
  assign s_axi_rdata = cur.rdata;
  assign s_axi_rresp = cur.rresp;
  assign analog_route = active_route;
  assign conversion_done_flag = cur.done_flag;
  assign irq = |(cur.irq_status & cur.irq_enable);

  // ==========================================================
  // Assertions
  a_sel_reset_zero: assert property (@(posedge aclk) !aresetn |=> cur.sel == 8'h00)
    else $error("select register not zero after reset");
  a_lock_during_busy: assert property (@(posedge aclk) disable iff (!aresetn)
    (cur.state == BUSY && !conversion_last) |=> $stable(cur.active))
    else $error("selection changed during conversion");
  a_copy_when_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    (cur.state == IDLE) |-> ##1 (cur.state == BUSY || cur.active == cur.sel))
    else $error("selection not copied while idle");
  a_done_on_last: assert property (@(posedge aclk) disable iff (!aresetn)
    (cur.state == BUSY && conversion_last) |=> conversion_done_flag && cur.state == IDLE)
    else $error("completion flag not set");
  a_align_left: assert property (@(posedge aclk) disable iff (!aresetn)
    cur.sel.result_left_align |-> result_word[5:0] == 6'h00 && result_word[15:6] == cur.result)
    else $error("left alignment wrong");
  a_align_right: assert property (@(posedge aclk) disable iff (!aresetn)
    !cur.sel.result_left_align |-> result_word[15:10] == 6'h00 && result_word[9:0] == cur.result)
    else $error("right alignment wrong");
  a_diff_clamp: assert property (@(posedge aclk) disable iff (!aresetn)
    (cur.state == BUSY && conversion_last && active_route.differential && raw_sample[10:9] == 2'b10)
    |=> cur.result == 10'h1ff)
    else $error("differential clamp wrong");
  a_se_clamp: assert property (@(posedge aclk) disable iff (!aresetn)
    (cur.state == BUSY && conversion_last && !active_route.differential && raw_sample[10])
    |=> cur.result == 10'h3ff)
    else $error("single-ended clamp wrong");
  a_ground_route: assert property (@(posedge aclk) disable iff (!aresetn)
    cur.active.channel_code == 5'h1f |-> analog_route.positive_input == 4'h9 && !analog_route.differential)
    else $error("ground route wrong");
  a_pair_two: assert property (@(posedge aclk) disable iff (!aresetn)
    cur.active.channel_code inside {[5'h18:5'h1d]} |-> analog_route.negative_input == 4'h2)
    else $error("second pair group wrong");
  a_reserved_ref: assert property (@(posedge aclk) disable iff (!aresetn)
    cur.active.reference_select == 2'h2 |-> !analog_route.valid)
    else $error("reserved reference routed");

  c_conversion: cover property (@(posedge aclk) conversion_start ##[1:40] conversion_last);
  c_write_busy: cover property (@(posedge aclk) cur.state == BUSY && wr_fire);
  c_irq: cover property (@(posedge aclk) irq);
  c_left: cover property (@(posedge aclk) cur.done_flag && cur.sel.result_left_align);
endmodule // adc_select

`default_nettype wire

// ==== core/adc_select_defs.svh ====
// Register offsets, field positions, reset values and codes for the converter select block
// Included by the design module and the test bench
`ifndef ADC_SELECT_DEFS_SVH
`define ADC_SELECT_DEFS_SVH

`define SEL_ADDR 12'h07c
`define RESULT_LOW_ADDR 12'h074
`define RESULT_HIGH_ADDR 12'h078
`define IRQ_STATUS_ADDR 12'h080
`define IRQ_CLEAR_ADDR 12'h084
`define IRQ_ENABLE_ADDR 12'h088
`define CONV_STATUS_ADDR 12'h08c
`define SEL_RESET 8'h00
`define REF_MSB 7
`define REF_LSB 6
`define ALIGN_BIT 5
`define CHAN_MSB 4
`define CHAN_LSB 0
`define REF_EXTERNAL 2'h0
`define REF_SUPPLY 2'h1
`define REF_RESERVED 2'h2
`define REF_INTERNAL 2'h3
`define CHAN_SE_LAST 5'h07
`define CHAN_DIFF1_FIRST 5'h10
`define CHAN_DIFF2_FIRST 5'h18
`define CHAN_DIFF2_LAST 5'h1d
`define CHAN_BANDGAP 5'h1e
`define CHAN_GROUND 5'h1f
`define SE_MAX 10'h3ff
`define DIFF_MAX 10'h1ff
`define DIFF_MIN 10'h200
`define SLVERR 2'h2
`define OKAY 2'h0

`endif

// ==== core/adc_select_pkg.sv ====
// Types for the converter input select and result format block
// Assumes the defs header is on the include path
package adc_select_pkg;
  typedef struct packed
  {
    logic [1:0] reference_select;
    logic result_left_align;
    logic [4:0] channel_code;
  } sel_type;

  typedef enum logic [1:0]
  {
    IDLE = 2'b01,
    BUSY = 2'b10
  } conv_state_type;

  typedef struct packed
  {
    logic valid;
    logic [1:0] reference_select;
    logic [3:0] positive_input;
    logic [3:0] negative_input;
    logic differential;
  } analog_route_type;

  typedef struct packed
  {
    sel_type sel;
    sel_type active;
    conv_state_type state;
    logic [9:0] result;
    logic [1:0] irq_status;
    logic [1:0] irq_enable;
    logic done_flag;
    logic aw_held;
    logic [11:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_type;
endpackage

// ==== verification/test_adc_select.sv ====
// Self-checking bench for the converter input select and result format block
// Drives the register bus and the converter pulses itself; expects the defs header on the include path
`timescale 1ns/1ps
`default_nettype none
`include "adc_select_defs.svh"

module test_adc_select;
  import adc_select_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hf;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [11:0] araddr = 12'h000;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic conv_start = 1'b0;
  logic conv_last = 1'b0;
  logic [10:0] raw = 11'h000;
  logic awready, wready, bvalid, arready, rvalid, done, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  analog_route_type route;
  int failures = 0;
  int n_tests = 0;
  int codes [9] = '{0, 7, 8, 16, 23, 24, 29, 30, 31};
  int pos [9] = '{0, 7, 0, 0, 7, 0, 5, 8, 9};
  int neg [9] = '{15, 15, 15, 1, 1, 2, 2, 15, 15};

  always #2.5 aclk = ~aclk;

  adc_select adc_select_inst
  (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .conversion_start(conv_start),
    .conversion_last(conv_last), .raw_sample(raw), .analog_route(route),
    .conversion_done_flag(done), .irq(irq)
  );

  // ==========================================
  // Checking and closing
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    if (failures == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic hang();
    failures++;
    close_out();
  endtask

  // ==========================================
  // Register bus master
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    tb = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 50 && !tb; i++)
    begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      if (tb)
        chk(bresp, er);
      @(posedge aclk);
      if (ta)
        awvalid <= 1'b0;
      if (tw)
        wvalid <= 1'b0;
      if (tb)
        bready <= 1'b0;
    end
    if (!tb)
      hang();
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
    logic ta, tr;
    tr = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 50 && !tr; i++)
    begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      if (tr)
      begin
        chk(rdata & m, e);
        chk(rresp, er);
      end
      @(posedge aclk);
      if (ta)
        arvalid <= 1'b0;
      if (tr)
        rready <= 1'b0;
    end
    if (!tr)
      hang();
  endtask

  // ==========================================
  // Converter pulses
  task automatic begin_conv();
    @(posedge aclk);
    conv_start <= 1'b1;
    @(posedge aclk);
    conv_start <= 1'b0;
  endtask

  task automatic end_conv(input logic [10:0] v);
    @(posedge aclk);
    conv_last <= 1'b1;
    raw <= v;
    @(posedge aclk);
    conv_last <= 1'b0;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
  endtask

  task automatic conv(input logic [10:0] v);
    begin_conv();
    end_conv(v);
  endtask

  task automatic res(input logic [7:0] lo, input logic [7:0] hi);
    rd(`RESULT_LOW_ADDR, 32'h0000_00ff, {24'h00_0000, lo}, `OKAY);
    rd(`RESULT_HIGH_ADDR, 32'h0000_00ff, {24'h00_0000, hi}, `OKAY);
  endtask

  // ==========================================
  // Scenarios
  task automatic s_reset();
    rd(`SEL_ADDR, 32'h0000_00ff, 32'h0000_0000, `OKAY);
    chk(irq, 1'b0);
    chk(done, 1'b0);
    wr(`SEL_ADDR, 32'h0000_00ff, `OKAY);
    rd(`SEL_ADDR, 32'h0000_00ff, 32'h0000_00ff, `OKAY);
    wstrb <= 4'h0;
    wr(`SEL_ADDR, 32'h0000_0000, `OKAY);
    rd(`SEL_ADDR, 32'h0000_00ff, 32'h0000_00ff, `OKAY);
    wstrb <= 4'hf;
    wr(12'h0f0, 32'h0000_0001, `SLVERR);
    rd(12'h0f0, 32'h0000_0000, 32'h0000_0000, `SLVERR);
  endtask

  task automatic s_route();
    for (int r = 0; r < 4; r++)
    begin
      wr(`SEL_ADDR, r << 6, `OKAY);
      repeat (2) @(negedge aclk);
      chk(route.reference_select, r[1:0]);
      chk(route.valid, r != 2);
    end
    for (int k = 0; k < 9; k++)
    begin
      wr(`SEL_ADDR, codes[k] | 32'h40, `OKAY);
      repeat (2) @(negedge aclk);
      chk(route.valid, codes[k] != 8);
      if (codes[k] != 8)
        chk(route.positive_input, pos[k][3:0]);
      chk(route.differential, codes[k] >= 16 && codes[k] <= 29);
      if (neg[k] != 15)
        chk(route.negative_input, neg[k][3:0]);
    end
  endtask

  task automatic s_hold();
    wr(`SEL_ADDR, 32'h0000_0001, `OKAY);
    begin_conv();
    wr(`SEL_ADDR, 32'h0000_00fb, `OKAY);
    @(negedge aclk);
    chk(route.positive_input, 4'h1);
    chk(route.reference_select, 2'h0);
    rd(`CONV_STATUS_ADDR, 32'h0000_0003, 32'h0000_0002, `OKAY);
    end_conv(11'h3a3);
    chk(done, 1'b1);
    rd(`CONV_STATUS_ADDR, 32'h0000_0003, 32'h0000_0001, `OKAY);
    rd(`IRQ_STATUS_ADDR, 32'h0000_0003, 32'h0000_0003, `OKAY);
    res(8'hc0, 8'he8);
    chk({route.positive_input, route.negative_input, route.differential}, 9'h065);
    wr(`SEL_ADDR, 32'h0000_00db, `OKAY);
    res(8'ha3, 8'h03);
  endtask

  task automatic s_clamp();
    wr(`SEL_ADDR, 32'h0000_00fb, `OKAY);
    conv(11'h400);
    res(8'hc0, 8'h7f);
    conv(11'h200);
    res(8'h00, 8'h80);
    wr(`SEL_ADDR, 32'h0000_0000, `OKAY);
    conv(11'h400);
    res(8'hff, 8'h03);
    conv(11'h000);
    res(8'h00, 8'h00);
  endtask

  task automatic s_irq();
    wr(`IRQ_CLEAR_ADDR, 32'h0000_0003, `OKAY);
    wr(`IRQ_ENABLE_ADDR, 32'h0000_0001, `OKAY);
    rd(`IRQ_ENABLE_ADDR, 32'h0000_0003, 32'h0000_0001, `OKAY);
    conv(11'h055);
    chk(irq, 1'b1);
    rd(`IRQ_STATUS_ADDR, 32'h0000_0001, 32'h0000_0001, `OKAY);
    wr(`IRQ_CLEAR_ADDR, 32'h0000_0003, `OKAY);
    @(negedge aclk);
    chk(irq, 1'b0);
    chk(done, 1'b0);
    wr(`IRQ_ENABLE_ADDR, 32'h0000_0000, `OKAY);
    conv(11'h055);
    chk(done, 1'b1);
    chk(irq, 1'b0);
    rd(`IRQ_STATUS_ADDR, 32'h0000_0001, 32'h0000_0001, `OKAY);
  endtask

  // ==========================================
  // Main sequence
  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    s_reset();
    s_route();
    s_hold();
    s_clamp();
    s_irq();
    close_out();
  end
endmodule // test_adc_select

`default_nettype wire
